// ===== hdl/sfc_device.sv
// Serial channel with format and control registers on APB
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module sfc_device (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic standby, // Standby entry, clears like reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  output logic tx_empty_irq, // Transmit empty request
  output logic rx_full_irq, // Receive full request
  output logic rx_error_irq, // Receive error request
  sfc_link_if.dev link // Serial link
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic clr;
  logic access_wr;
  logic access_rd;
  sfc_pkg::sfc_reg_t sel;
  logic [7:0] format_q;
  logic [7:0] control_q;
  logic [7:0] thr_q;
  logic [7:0] rdr_q;
  logic [7:0] armed_q;
  logic [7:0] status;
  logic [31:0] prdata_q;
  logic tx_empty_flag_q, rx_full_flag_q, overrun_flag_q, fer_q, per_q, mpbr_q, mpbt_q;
  logic is_sync, seven, par_on, mp_on, multiproc_irq_en_on, odd;
  logic [5:0] pre_q;
  logic [5:0] pre_mask;
  logic tick;
  logic tx_busy_q;
  logic [11:0] tsr_q;
  logic [3:0] tx_left_q;
  logic [3:0] tx_ph_q;
  logic tx_load;
  logic [7:0] tx_data;
  logic txd_q, sck_q;
  logic rxd_q, rxd_p_q, fsck_q, fsck_p_q;
  logic rx_busy_q;
  logic [3:0] rx_ph_q;
  logic [3:0] rx_idx_q;
  logic [3:0] rx_len;
  logic [8:0] rsr_q;
  logic rx_done_q;
  logic rx_stop_q;
  logic [7:0] rx_byte;
  logic rx_extra;
  logic rx_keep;
  logic mp_hit;
  logic clr_st;
  logic rx_room;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign clr = sys_rst | standby;
  assign is_sync = format_q[sfc_pkg::FMT_SYNC];
  assign seven = ~is_sync & format_q[sfc_pkg::FMT_CHR7];
  assign mp_on = ~is_sync & format_q[sfc_pkg::FMT_MP];
  assign par_on = ~is_sync & ~mp_on & format_q[sfc_pkg::FMT_PAR];
  assign odd = par_on & format_q[sfc_pkg::FMT_ODD];
  assign multiproc_irq_en_on = mp_on & control_q[sfc_pkg::CTL_MULTIPROC_IRQ_EN];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign sel = sfc_pkg::sfc_decode(paddr);
  assign access_wr = psel & penable & pwrite;
  assign access_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (sel == sfc_pkg::REG_NONE);
  assign prdata = prdata_q;
  assign status = {tx_empty_flag_q, rx_full_flag_q, overrun_flag_q, fer_q, per_q, 1'b0, mpbr_q, mpbt_q};

  // Read data is latched in the setup cycle
  always_ff @(posedge clk)
  begin
    if (clr)
      prdata_q <= '0;
    else if (psel & ~penable)
    begin
      unique case (sel)
        sfc_pkg::REG_FORMAT: prdata_q <= {24'h000000, format_q};
        sfc_pkg::REG_CONTROL: prdata_q <= {24'h000000, control_q};
        sfc_pkg::REG_STATUS: prdata_q <= {24'h000000, status};
        sfc_pkg::REG_TXHOLD: prdata_q <= {24'h000000, thr_q};
        sfc_pkg::REG_RXHOLD: prdata_q <= {24'h000000, rdr_q};
        sfc_pkg::REG_NONE: prdata_q <= '0;
      endcase
    end
  end

  // Status bits read as one arm their clear
  always_ff @(posedge clk)
  begin
    if (clr)
      armed_q <= 8'h00;
    else if (access_rd & (sel == sfc_pkg::REG_STATUS))
      armed_q <= prdata_q[7:0];
  end

  // Format register
  always_ff @(posedge clk)
  begin
    if (clr)
      format_q <= sfc_pkg::FORMAT_RST;
    else if (access_wr & (sel == sfc_pkg::REG_FORMAT))
      format_q <= pwdata[7:0];
  end

  // Control register; a wake character drops the wake enable
  always_ff @(posedge clk)
  begin
    if (clr)
      control_q <= sfc_pkg::CONTROL_RST;
    else
    begin
      if (access_wr & (sel == sfc_pkg::REG_CONTROL))
        control_q <= pwdata[7:0];
      if (mp_hit)
        control_q[sfc_pkg::CTL_MULTIPROC_IRQ_EN] <= 1'b0;
    end
  end

  // Transmit holding register
  always_ff @(posedge clk)
  begin
    if (clr)
      thr_q <= sfc_pkg::TXHOLD_RST;
    else if (access_wr & (sel == sfc_pkg::REG_TXHOLD))
      thr_q <= pwdata[7:0];
  end

  // ----------------------------------------------------------------
  // Status flags: a hardware set wins over a software clear
  // ----------------------------------------------------------------
  assign clr_st = access_wr & (sel == sfc_pkg::REG_STATUS);
  // A character landing in the cycle its full flag is cleared is kept, not overrun
  assign rx_room = ~rx_full_flag_q | (clr_st & ~pwdata[sfc_pkg::ST_RX_FULL_FLAG] & armed_q[sfc_pkg::ST_RX_FULL_FLAG]);

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      tx_empty_flag_q <= 1'b1;
      rx_full_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
      fer_q <= 1'b0;
      per_q <= 1'b0;
      mpbr_q <= 1'b0;
      mpbt_q <= 1'b0;
    end
    else
    begin
      if (clr_st)
      begin
        mpbt_q <= pwdata[sfc_pkg::ST_MPBT];
        if (~pwdata[sfc_pkg::ST_TX_EMPTY_FLAG] & armed_q[sfc_pkg::ST_TX_EMPTY_FLAG])
          tx_empty_flag_q <= 1'b0;
        if (~pwdata[sfc_pkg::ST_RX_FULL_FLAG] & armed_q[sfc_pkg::ST_RX_FULL_FLAG])
          rx_full_flag_q <= 1'b0;
        if (~pwdata[sfc_pkg::ST_OVERRUN_FLAG] & armed_q[sfc_pkg::ST_OVERRUN_FLAG])
          overrun_flag_q <= 1'b0;
        if (~pwdata[sfc_pkg::ST_FER] & armed_q[sfc_pkg::ST_FER])
          fer_q <= 1'b0;
        if (~pwdata[sfc_pkg::ST_PER] & armed_q[sfc_pkg::ST_PER])
          per_q <= 1'b0;
      end
      if (tx_load | ~control_q[sfc_pkg::CTL_TE])
        tx_empty_flag_q <= 1'b1;
      if (rx_keep)
      begin
        if (mp_on)
          mpbr_q <= rx_extra;
        if (~rx_room)
          overrun_flag_q <= 1'b1;
        else
        begin
          rx_full_flag_q <= 1'b1;
          if (~is_sync & ~rx_stop_q)
            fer_q <= 1'b1;
          if (par_on & ((^rx_byte ^ rx_extra) != odd))
            per_q <= 1'b1;
        end
      end
    end
  end

  // Receive holding register; left alone on overrun
  always_ff @(posedge clk)
  begin
    if (clr)
      rdr_q <= sfc_pkg::RXHOLD_RST;
    else if (rx_keep & rx_room)
      rdr_q <= rx_byte;
  end

  // Requests; removed with their flag or enable
  assign tx_empty_irq = control_q[sfc_pkg::CTL_TIE] & tx_empty_flag_q;
  assign rx_full_irq = control_q[sfc_pkg::CTL_RIE] & rx_full_flag_q;
  assign rx_error_irq = control_q[sfc_pkg::CTL_RIE] & (overrun_flag_q | fer_q | per_q);

  // ----------------------------------------------------------------
  // Baud prescaler
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (format_q[sfc_pkg::FMT_CKS +: 2])
      2'b00: pre_mask = 6'h00;
      2'b01: pre_mask = 6'h03;
      2'b10: pre_mask = 6'h0F;
      2'b11: pre_mask = 6'h3F;
    endcase
  end
  assign tick = &(pre_q | ~pre_mask);

  always_ff @(posedge clk)
  begin
    if (clr)
      pre_q <= 6'h00;
    else
      pre_q <= pre_q + 6'h01;
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign tx_load = control_q[sfc_pkg::CTL_TE] & ~tx_empty_flag_q & ~tx_busy_q;
  assign tx_data = seven ? {1'b0, thr_q[6:0]} : thr_q;

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      tx_busy_q <= 1'b0;
      tsr_q <= 12'hFFF;
      tx_left_q <= 4'h0;
      tx_ph_q <= 4'h0;
    end
    else if (~tx_busy_q)
    begin
      if (tx_load)
      begin
        tx_busy_q <= 1'b1;
        tx_ph_q <= 4'h0;
        {tx_left_q, tsr_q} <= sfc_pkg::sfc_frame(tx_data, is_sync, seven, par_on | mp_on,
            mp_on ? mpbt_q : (^tx_data ^ odd), ~is_sync & format_q[sfc_pkg::FMT_STOP2]);
      end
    end
    else if (tick)
    begin
      tx_ph_q <= tx_ph_q + 4'h1;
      if (tx_ph_q == sfc_pkg::PH_LAST)
      begin
        tsr_q <= {1'b1, tsr_q[11:1]};
        tx_left_q <= tx_left_q - 4'h1;
        if (tx_left_q == 4'h1)
          tx_busy_q <= 1'b0;
      end
    end
  end

  // Line drivers; clock low in the first half of each sync bit
  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      txd_q <= 1'b1;
      sck_q <= 1'b1;
    end
    else
    begin
      txd_q <= tx_busy_q ? tsr_q[0] : 1'b1;
      sck_q <= (tx_busy_q & is_sync) ? tx_ph_q[3] : 1'b1;
    end
  end
  assign link.dev_txd = txd_q;
  assign link.dev_sck = sck_q;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  assign rx_len = is_sync ? 4'h8 : ((seven ? 4'h7 : 4'h8) + {3'b000, par_on | mp_on});
  assign rx_byte = seven ? {1'b0, rsr_q[6:0]} : rsr_q[7:0];
  assign rx_extra = seven ? rsr_q[7] : rsr_q[8];
  assign mp_hit = rx_done_q & multiproc_irq_en_on & rx_extra;
  assign rx_keep = rx_done_q & (~multiproc_irq_en_on | rx_extra);

  // Line sampling and edge history
  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      rxd_q <= 1'b1;
      rxd_p_q <= 1'b1;
      fsck_q <= 1'b1;
      fsck_p_q <= 1'b1;
    end
    else
    begin
      rxd_q <= link.far_txd;
      rxd_p_q <= rxd_q;
      fsck_q <= link.far_sck;
      fsck_p_q <= fsck_q;
    end
  end

  // Bit collection, LSB first
  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      rx_busy_q <= 1'b0;
      rx_ph_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rsr_q <= 9'h000;
      rx_done_q <= 1'b0;
      rx_stop_q <= 1'b1;
    end
    else
    begin
      rx_done_q <= 1'b0;
      if (~control_q[sfc_pkg::CTL_RE])
      begin
        rx_busy_q <= 1'b0;
        rx_idx_q <= 4'h0;
      end
      else if (is_sync)
      begin
        if (fsck_q & ~fsck_p_q)
        begin
          rsr_q[rx_idx_q] <= rxd_q;
          rx_idx_q <= (rx_idx_q == 4'h7) ? 4'h0 : rx_idx_q + 4'h1;
          rx_done_q <= (rx_idx_q == 4'h7);
        end
      end
      else if (~rx_busy_q)
      begin
        if (~rxd_q & rxd_p_q)
        begin
          rx_busy_q <= 1'b1;
          rx_ph_q <= 4'h0;
          rx_idx_q <= 4'h0;
        end
      end
      else if (tick)
      begin
        rx_ph_q <= rx_ph_q + 4'h1;
        if (rx_ph_q == sfc_pkg::PH_MID)
        begin
          rx_idx_q <= rx_idx_q + 4'h1;
          if (rx_idx_q == 4'h0)
            rx_busy_q <= ~rxd_q;
          else if (rx_idx_q <= rx_len)
            rsr_q[rx_idx_q - 4'h1] <= rxd_q;
          else
          begin
            rx_busy_q <= 1'b0;
            rx_stop_q <= rxd_q;
            rx_done_q <= 1'b1;
          end
        end
      end
    end
  end

endmodule : sfc_device

// ===== hdl/sfc_link_if.sv
// Serial link between the channel and the remote serial device
`timescale 1ns/1ps
interface sfc_link_if;
  logic dev_txd; // Channel transmit data
  logic dev_sck; // Channel serial clock, synchronous mode
  logic far_txd; // Remote transmit data
  logic far_sck; // Remote serial clock, synchronous mode

  modport dev (output dev_txd, output dev_sck, input far_txd, input far_sck);
  modport far (input dev_txd, input dev_sck, output far_txd, output far_sck);
endinterface : sfc_link_if

// ===== hdl/sfc_partner.sv
// Remote serial device at the far end of the link
`timescale 1ns/1ps
module sfc_partner (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [15:0] bit_cycles, // Clock cycles per bit, at least 2
  input wire logic cfg_sync, // Synchronous mode
  input wire logic cfg_seven, // Seven data bits
  input wire logic cfg_par, // Parity on
  input wire logic cfg_odd, // Odd parity
  input wire logic cfg_stop2, // Two stop bits
  input wire logic cfg_mp, // Multiprocessor format
  input wire logic tx_valid, // Character offered
  input wire logic [7:0] tx_data, // Character to send
  input wire logic tx_mpb, // Multiprocessor bit to send
  output logic tx_ready, // Transmitter idle
  output logic rx_valid, // Character received pulse
  output logic [7:0] rx_data, // Received character
  output logic rx_extra, // Received parity or multiprocessor bit
  output logic rx_stop_ok, // First stop bit was high
  sfc_link_if.far link // Serial link
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic seven, extra_on;
  logic [7:0] dd;
  logic [15:0] half;
  logic tx_busy_q;
  logic [11:0] tsr_q;
  logic [3:0] tx_left_q;
  logic [15:0] tx_cnt_q;
  logic txd_q, sck_q;
  logic dtx_p_q, dsck_p_q;
  logic rx_busy_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [3:0] rx_len;
  logic [8:0] rsr_q;
  logic rx_valid_q;
  logic [7:0] rx_data_q;
  logic rx_extra_q, rx_stop_q;

  assign seven = ~cfg_sync & cfg_seven;
  assign extra_on = ~cfg_sync & (cfg_par | cfg_mp);
  assign dd = seven ? {1'b0, tx_data[6:0]} : tx_data;
  assign half = {1'b0, bit_cycles[15:1]};
  assign tx_ready = ~tx_busy_q;

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_busy_q <= 1'b0;
      tsr_q <= 12'hFFF;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 16'h0000;
    end
    else if (~tx_busy_q)
    begin
      if (tx_valid)
      begin
        tx_busy_q <= 1'b1;
        tx_cnt_q <= bit_cycles - 16'h0001;
        {tx_left_q, tsr_q} <= sfc_pkg::sfc_frame(dd, cfg_sync, seven, extra_on,
            cfg_mp ? tx_mpb : (^dd ^ cfg_odd), ~cfg_sync & cfg_stop2);
      end
    end
    else if (tx_cnt_q == 16'h0000)
    begin
      tx_cnt_q <= bit_cycles - 16'h0001;
      tsr_q <= {1'b1, tsr_q[11:1]};
      tx_left_q <= tx_left_q - 4'h1;
      if (tx_left_q == 4'h1)
        tx_busy_q <= 1'b0;
    end
    else
      tx_cnt_q <= tx_cnt_q - 16'h0001;
  end

  // Line drivers; clock rises at mid-bit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      txd_q <= 1'b1;
      sck_q <= 1'b1;
    end
    else
    begin
      txd_q <= tx_busy_q ? tsr_q[0] : 1'b1;
      sck_q <= (tx_busy_q & cfg_sync) ? (tx_cnt_q < half) : 1'b1;
    end
  end
  assign link.far_txd = txd_q;
  assign link.far_sck = sck_q;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  assign rx_len = cfg_sync ? 4'h8 : ((seven ? 4'h7 : 4'h8) + {3'b000, extra_on});
  assign rx_valid = rx_valid_q;
  assign rx_data = rx_data_q;
  assign rx_extra = rx_extra_q;
  assign rx_stop_ok = rx_stop_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dtx_p_q <= 1'b1;
      dsck_p_q <= 1'b1;
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_idx_q <= 4'h0;
      rsr_q <= 9'h000;
      rx_valid_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_extra_q <= 1'b0;
      rx_stop_q <= 1'b1;
    end
    else
    begin
      dtx_p_q <= link.dev_txd;
      dsck_p_q <= link.dev_sck;
      rx_valid_q <= 1'b0;
      if (cfg_sync)
      begin
        if (link.dev_sck & ~dsck_p_q)
        begin
          rsr_q[rx_idx_q] <= link.dev_txd;
          rx_idx_q <= (rx_idx_q == 4'h7) ? 4'h0 : rx_idx_q + 4'h1;
          if (rx_idx_q == 4'h7)
          begin
            rx_valid_q <= 1'b1;
            rx_data_q <= {link.dev_txd, rsr_q[6:0]};
            rx_stop_q <= 1'b1;
          end
        end
      end
      else if (~rx_busy_q)
      begin
        if (~link.dev_txd & dtx_p_q)
        begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= half;
          rx_idx_q <= 4'h0;
        end
      end
      else if (rx_cnt_q != 16'h0000)
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      else
      begin
        rx_cnt_q <= bit_cycles - 16'h0001;
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0)
          rx_busy_q <= ~link.dev_txd;
        else if (rx_idx_q <= rx_len)
          rsr_q[rx_idx_q - 4'h1] <= link.dev_txd;
        else
        begin
          rx_busy_q <= 1'b0;
          rx_valid_q <= 1'b1;
          rx_data_q <= seven ? {1'b0, rsr_q[6:0]} : rsr_q[7:0];
          rx_extra_q <= seven ? rsr_q[7] : rsr_q[8];
          rx_stop_q <= link.dev_txd;
        end
      end
    end
  end

endmodule : sfc_partner

// ===== hdl/sfc_pkg.sv
// Shared constants, types and frame builder for the serial format control block
package sfc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FORMAT = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_TXHOLD = 8'h0C;
  localparam logic [7:0] OFS_RXHOLD = 8'h10;

  typedef enum logic [2:0] {
    REG_FORMAT = 3'b000,
    REG_CONTROL = 3'b001,
    REG_STATUS = 3'b010,
    REG_TXHOLD = 3'b011,
    REG_RXHOLD = 3'b100,
    REG_NONE = 3'b111
  } sfc_reg_t;

  // Format register fields
  localparam int FMT_SYNC = 7;
  localparam int FMT_CHR7 = 6;
  localparam int FMT_PAR = 5;
  localparam int FMT_ODD = 4;
  localparam int FMT_STOP2 = 3;
  localparam int FMT_MP = 2;
  localparam int FMT_CKS = 0;
  // Control register fields
  localparam int CTL_TIE = 7;
  localparam int CTL_RIE = 6;
  localparam int CTL_TE = 5;
  localparam int CTL_RE = 4;
  localparam int CTL_MULTIPROC_IRQ_EN = 3;
  // Status register fields
  localparam int ST_TX_EMPTY_FLAG = 7;
  localparam int ST_RX_FULL_FLAG = 6;
  localparam int ST_OVERRUN_FLAG = 5;
  localparam int ST_FER = 4;
  localparam int ST_PER = 3;
  localparam int ST_MPBR = 1;
  localparam int ST_MPBT = 0;

  // Reset values
  localparam logic [7:0] FORMAT_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] TXHOLD_RST = 8'hFF;
  localparam logic [7:0] RXHOLD_RST = 8'h00;

  // Bit timing: sixteen prescaled ticks per bit, sampled mid-bit
  localparam logic [3:0] PH_MID = 4'h7;
  localparam logic [3:0] PH_LAST = 4'hF;

  // Address decode shared by the read and write paths
  function automatic sfc_reg_t sfc_decode(input logic [7:0] a);
    unique case (a)
      OFS_FORMAT: return REG_FORMAT;
      OFS_CONTROL: return REG_CONTROL;
      OFS_STATUS: return REG_STATUS;
      OFS_TXHOLD: return REG_TXHOLD;
      OFS_RXHOLD: return REG_RXHOLD;
      default: return REG_NONE;
    endcase
  endfunction : sfc_decode

  // Builds a frame, LSB first; returns {bit count, bits}
  function automatic logic [15:0] sfc_frame(input logic [7:0] d, input logic sync, input logic seven,
                                            input logic extra_on, input logic extra, input logic stop2);
    logic [11:0] f;
    logic [3:0] n;
    logic [3:0] len;
    f = 12'hFFF;
    n = seven ? 4'h7 : 4'h8;
    if (sync)
    begin
      f = {4'hF, d};
      len = 4'h8;
    end
    else
    begin
      f[0] = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        if (i < int'(n))
          f[i+1] = d[i];
      end
      if (extra_on)
        f[n+4'h1] = extra;
      len = n + 4'h2 + {3'b000, extra_on} + {3'b000, stop2};
    end
    return {len, f};
  endfunction : sfc_frame

endpackage : sfc_pkg

// ===== tb/serial_format_control_tb.sv
// Self-checking bench for the channel and the remote device
`timescale 1ns/1ps
module serial_format_control_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk = 0, sys_rst = 1, standby = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00, d, m, tx_data = 8'h00, rx_data;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tx_empty_irq, rx_full_irq, rx_error_irq, tx_ready, rx_valid, rx_extra, rx_stop_ok;
  logic seven = 0, par = 0, odd = 0, stop2 = 0, p_odd = 0, tx_valid = 0, mp = 0;
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h80, 8'hFF, 8'h00, 8'h00};
  int bad_count = 0, cmp_count = 0, n, i, cyc = 0;
  sfc_link_if u_sfc_link_if();
  sfc_device u_sfc_device (.clk(clk), .sys_rst(sys_rst), .standby(standby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .link(u_sfc_link_if));
  sfc_partner u_sfc_partner (.clk(clk), .sys_rst(sys_rst), .bit_cycles(16'h0010), .cfg_sync(1'b0),
    .cfg_seven(seven), .cfg_par(par), .cfg_odd(p_odd), .cfg_stop2(stop2), .cfg_mp(mp), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_mpb(mp), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_extra(rx_extra), .rx_stop_ok(rx_stop_ok), .link(u_sfc_link_if));
  sfc_link_sva u_sfc_link_sva (.clk(clk), .sys_rst(sys_rst), .dev_txd(u_sfc_link_if.dev_txd),
    .dev_sck(u_sfc_link_if.dev_sck), .far_txd(u_sfc_link_if.far_txd), .far_sck(u_sfc_link_if.far_sck));
  // ----------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------
  initial forever #5 clk = ~clk;
  // Cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One APB transfer, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    chk("pready", 32'h1, {31'h0, pready});
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic pbit(input logic [7:0] x, input logic o);
    return (^x) ^ o;
  endfunction : pbit
  task end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    i = $urandom(32'h363A);
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, last place unmapped
    for (i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset read", {24'h0, rv[i]}, rd);
    end
    chk("pslverr", 32'h1, {31'h0, err});
    chk("tx irq off", 32'h0, {31'h0, tx_empty_irq});
    // Read back with every prescale code, then standby clears
    for (i = 0; i < 4; i++)
    begin
      d = (8'($urandom) & 8'hFC) | 8'(i);
      apb(1'b1, sfc_pkg::OFS_FORMAT, {24'h0, d});
      apb(1'b1, sfc_pkg::OFS_CONTROL, {24'h0, d & 8'hF8});
      apb(1'b0, sfc_pkg::OFS_FORMAT, 32'h0);
      chk("format", {24'h0, d}, rd);
      apb(1'b0, sfc_pkg::OFS_CONTROL, 32'h0);
      chk("control", {24'h0, d & 8'hF8}, rd);
    end
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    apb(1'b0, sfc_pkg::OFS_FORMAT, 32'h0);
    chk("standby format", 32'h0, rd);
    apb(1'b1, sfc_pkg::OFS_STATUS, 32'h0);
    apb(1'b0, sfc_pkg::OFS_STATUS, 32'h0);
    chk("empty held", 32'h80, rd & 32'hF8);
    // Both directions with random formats, last one with a parity mismatch
    for (i = 0; i < 6; i++)
    begin
      d = 8'($urandom);
      seven <= d[0];
      par <= d[1] | (i == 5);
      odd <= d[2];
      p_odd <= d[2] ^ (i == 5);
      stop2 <= d[3];
      mp <= (i == 4);
      @(posedge clk);
      m = seven ? 8'h7F : 8'hFF;
      apb(1'b1, sfc_pkg::OFS_CONTROL, 32'h0);
      apb(1'b1, sfc_pkg::OFS_FORMAT, {25'h0, seven, par, odd, stop2, mp, 2'b00});
      apb(1'b1, sfc_pkg::OFS_CONTROL, 32'hF0);
      d = 8'($urandom);
      apb(1'b1, sfc_pkg::OFS_TXHOLD, {24'h0, d});
      apb(1'b0, sfc_pkg::OFS_STATUS, 32'h0);
      apb(1'b1, sfc_pkg::OFS_STATUS, 32'h0);
      for (n = 0; n < 1000 && rx_valid !== 1'b1; n++) @(posedge clk);
      chk("frame seen", 32'h1, {31'h0, rx_valid});
      chk("sent data", {24'h0, d & m}, {24'h0, rx_data});
      if (mp)
        chk("mp bit", 32'h0, {31'h0, rx_extra});
      else if (par)
        chk("parity bit", {31'h0, pbit(d & m, odd)}, {31'h0, rx_extra});
      chk("stop bit", 32'h1, {31'h0, rx_stop_ok});
      chk("tx irq", 32'h1, {31'h0, tx_empty_irq});
      d = 8'($urandom);
      tx_valid <= 1'b1;
      tx_data <= d;
      @(posedge clk);
      while (tx_ready !== 1'b1) @(posedge clk);
      tx_valid <= 1'b0;
      for (n = 0; n < 1000 && rx_full_irq !== 1'b1; n++) @(posedge clk);
      chk("rx full irq", 32'h1, {31'h0, rx_full_irq});
      apb(1'b0, sfc_pkg::OFS_RXHOLD, 32'h0);
      chk("received data", {24'h0, d & m}, rd);
      apb(1'b1, sfc_pkg::OFS_CONTROL, 32'hE0);
      apb(1'b0, sfc_pkg::OFS_STATUS, 32'h0);
      chk("status", {24'h0, 4'hC, (i == 5), 3'b000}, rd & 32'hF8);
      chk("error irq", {31'h0, (i == 5)}, {31'h0, rx_error_irq});
      apb(1'b1, sfc_pkg::OFS_STATUS, 32'h80);
      @(posedge clk);
      chk("rx irq", 32'h0, {31'h0, rx_full_irq});
    end
    end_of_test();
  end
endmodule : serial_format_control_tb

// ===== tb/sfc_link_sva.sv
// Checker of the serial link wires between the two ends
`timescale 1ns/1ps
module sfc_link_sva (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Reset
  input wire logic dev_txd, // Channel data out
  input wire logic dev_sck, // Channel clock
  input wire logic far_txd, // Remote data out
  input wire logic far_sck // Remote clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic dp_q;
  logic fp_q;
  logic [15:0] dr_q;
  logic [15:0] fr_q;
  // Low run length on each data line, bench runs sixteen clocks a bit
  always_ff @(posedge clk)
  begin
    dp_q <= sys_rst | dev_txd;
    fp_q <= sys_rst | far_txd;
    dr_q <= (dev_txd != dp_q) ? 16'h0001 : dr_q + 16'h0001;
    fr_q <= (far_txd != fp_q) ? 16'h0001 : fr_q + 16'h0001;
  end
  property p_tx_whole; (dev_txd && !dp_q) |-> dr_q[3:0] == 4'h0; endproperty
  a_tx_whole: assert property (p_tx_whole) else $error("dev_txd low run not whole bits");
  property p_tx_max; (dev_txd && !dp_q) |-> dr_q <= 16'h00A0; endproperty
  a_tx_max: assert property (p_tx_max) else $error("dev_txd low too long");
  property p_rx_whole; (far_txd && !fp_q) |-> fr_q[3:0] == 4'h0; endproperty
  a_rx_whole: assert property (p_rx_whole) else $error("far_txd low run not whole bits");
  property p_rx_max; (far_txd && !fp_q) |-> fr_q <= 16'h00A0; endproperty
  a_rx_max: assert property (p_rx_max) else $error("far_txd low too long");
  property p_start; $fell(dev_txd) |-> !dev_txd [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
  property p_high; $rose(dev_txd) |-> dev_txd [*8]; endproperty
  a_high: assert property (p_high) else $error("high bit too short");
  property p_sck; dev_sck; endproperty
  a_sck: assert property (p_sck) else $error("dev_sck moved in async mode");
  property p_far_sck; far_sck; endproperty
  a_far_sck: assert property (p_far_sck) else $error("far_sck moved in async mode");
endmodule : sfc_link_sva
